// *** src/vga_mem_path.sv ***
// VGA memory datapath with host mapping, refresh pixel path and trap logic.
`timescale 1ns/1ps
`default_nettype none
`include "vga_defs.svh"
module vga_mem_path
  import vga_pkg::*;
#(
  parameter int FRAME_LINES = 525
)(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [17:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire host_req_type host_req,
  output logic              host_ready,
  output logic              host_done,
  output logic      [7:0]   host_rdata,
  input  wire logic         io_valid,
  input  wire logic [15:0]  io_addr,
  output logic              smi_trap,
  output var fb_req_type    fb_req,
  input  wire logic [31:0]  fb_rdata,
  input  wire logic         mclk25_tick,
  input  wire logic         mclk28_tick,
  output logic      [15:0]  refresh_addr,
  input  wire logic [31:0]  refresh_data,
  output logic              dot_valid,
  output logic      [7:0]   dac_index
);

  // Refuse frame lengths that the ten-bit line counter cannot hold.
  if (FRAME_LINES < 2 || FRAME_LINES > 1023) begin : g_bad_lines
    $error("FRAME_LINES must lie between 2 and 1023");
  end

  // Software state.
  logic [2:0]  seg_trap_ctl;
  logic [31:0] region_trap_mask;
  logic [2:0]  io_range_trap_ctl;
  logic [15:0] gfx_ctl;
  logic [27:0] gfx_mask;
  logic [30:0] refresh_ctl;
  logic [5:0]  palette [16];

  // Field views of the control words.
  logic [1:0] write_mode, rop_sel, write_map, seg_map, read_plane_index;
  logic [2:0] rotate_amount;
  logic       read_mode, odd_even_read, odd_even_page_select;
  logic [3:0] plane_write_mask, plane_fill_select, plane_fill_value;
  logic [3:0] plane_match_value, plane_match_ignore, palette_input_mask;
  logic [7:0] latch_select_mask, chars_per_line;
  logic [1:0] addr_shift, pixel_format_field, color_select;
  logic [9:0] split_screen_row;
  logic       clk_sel28, dot_halve, char_nine;
  assign write_mode           = gfx_ctl[1:0];
  assign rop_sel              = gfx_ctl[3:2];
  assign rotate_amount        = gfx_ctl[6:4];
  assign read_mode            = gfx_ctl[7];
  assign read_plane_index     = gfx_ctl[9:8];
  assign write_map            = gfx_ctl[11:10];
  assign odd_even_read        = gfx_ctl[12];
  assign odd_even_page_select = gfx_ctl[13];
  assign seg_map              = gfx_ctl[15:14];
  assign plane_write_mask     = gfx_mask[3:0];
  assign plane_fill_select    = gfx_mask[7:4];
  assign plane_fill_value     = gfx_mask[11:8];
  assign plane_match_value    = gfx_mask[15:12];
  assign plane_match_ignore   = gfx_mask[19:16];
  assign latch_select_mask    = gfx_mask[27:20];
  assign clk_sel28            = refresh_ctl[0];
  assign dot_halve            = refresh_ctl[1];
  assign char_nine            = refresh_ctl[2];
  assign addr_shift           = refresh_ctl[4:3];
  assign pixel_format_field   = refresh_ctl[6:5];
  assign palette_input_mask   = refresh_ctl[10:7];
  assign split_screen_row     = refresh_ctl[20:11];
  assign chars_per_line       = refresh_ctl[28:21];
  assign color_select         = refresh_ctl[30:29];

  // APB decode; the slave never waits, so pready is tied high.
  logic [15:0] idx;
  logic        apb_wr, is_pal, mapped;
  logic [9:0]  scan_line;
  logic [15:0] char_addr;
  assign idx     = paddr[17:2];
  assign is_pal  = idx[15:4] == 12'(`IDX_PAL_BASE >> 4);
  assign apb_wr  = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // Read data mux; unmapped indices read zero and flag an error.
  always_comb begin
    mapped = 1'b1;
    prdata = 32'h00000000;
    if (is_pal) begin
      prdata = {26'h0000000, palette[idx[3:0]]};
    end else begin
      case (idx)
        `IDX_SEG_TRAP:    prdata = {29'h00000000, seg_trap_ctl};
        `IDX_REGION_MASK: prdata = region_trap_mask;
        `IDX_IO_TRAP:     prdata = {29'h00000000, io_range_trap_ctl};
        `IDX_GFX_CTL:     prdata = {16'h0000, gfx_ctl};
        `IDX_GFX_MASK:    prdata = {4'h0, gfx_mask};
        `IDX_REFRESH:     prdata = {1'b0, refresh_ctl};
        `IDX_STATUS:      prdata = {6'h00, scan_line, char_addr};
        default:          mapped = 1'b0;
      endcase
    end
  end

  // Register writes take effect at the access-phase edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg_trap_ctl      <= `SEG_TRAP_RESET;
      region_trap_mask  <= `REGION_RESET;
      io_range_trap_ctl <= `IO_TRAP_RESET;
      gfx_ctl           <= `GFX_CTL_RESET;
      gfx_mask          <= `GFX_MASK_RESET;
      refresh_ctl       <= `REFRESH_RESET;
    end else if (apb_wr) begin
      case (idx)
        `IDX_SEG_TRAP:    seg_trap_ctl      <= pwdata[2:0];
        `IDX_REGION_MASK: region_trap_mask  <= pwdata;
        `IDX_IO_TRAP:     io_range_trap_ctl <= pwdata[2:0];
        `IDX_GFX_CTL:     gfx_ctl           <= pwdata[15:0];
        `IDX_GFX_MASK:    gfx_mask          <= pwdata[27:0];
        `IDX_REFRESH:     refresh_ctl       <= pwdata[30:0];
        default:          ;
      endcase
    end
  end

  // Palette entries are plain storage, cleared at reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) palette[i] <= 6'h00;
    end else if (apb_wr && is_pal) begin
      palette[idx[3:0]] <= pwdata[5:0];
    end
  end

  // Host address decode for the selected mapping.
  logic        vga_hit, take;
  logic [16:0] seg;
  assign seg  = host_req.addr[31:15];
  always_comb begin
    case (seg_map)
      2'h0:    vga_hit = seg == `SEG_A_LO || seg == `SEG_A_HI;
      2'h1:    vga_hit = seg == `SEG_B_LO;
      2'h2:    vga_hit = seg == `SEG_B_HI;
      default: vga_hit = 1'b0;
    endcase
  end

  // Frame address and byte enables per write mapping.
  logic [15:0] fb_addr;
  logic [3:0]  fb_be;
  logic [1:0]  a_lo;
  assign a_lo = host_req.addr[1:0];
  always_comb begin
    fb_addr = host_req.addr[15:0];
    fb_be   = plane_write_mask;
    if (write_map == `MAP_ODD_EVEN) begin
      fb_addr = {host_req.addr[15:1], odd_even_page_select};
      fb_be   = (a_lo[0] ? 4'hA : 4'h5) & plane_write_mask;
    end else if (write_map == `MAP_QUAD) begin
      fb_addr = {host_req.addr[15:2], 2'h0};
      fb_be   = (4'h1 << a_lo) & plane_write_mask;
    end
  end

  // Write datapath: rotator, write mode, raster unit, latch select.
  logic [31:0] latch, mode_out, rop_out, wr_data;
  logic [7:0]  rot, sel_mask;
  assign rot = 8'((({host_req.data, host_req.data}) >> rotate_amount));
  always_comb begin
    sel_mask = latch_select_mask;
    for (int b = 0; b < 4; b++) begin
      case (write_mode)
        `WM_REPLICATE:   mode_out[b*8 +: 8] = {8{host_req.data[b]}};
        `WM_FILL_MASKED: mode_out[b*8 +: 8] = {8{plane_fill_value[b]}};
        default: // Mode 1 is not native and falls back to mode 0.
          mode_out[b*8 +: 8] = plane_fill_select[b] ?
                               {8{plane_fill_value[b]}} : rot;
      endcase
    end
    if (write_mode == `WM_FILL_MASKED) begin
      sel_mask = rot & latch_select_mask;
    end
    case (rop_sel)
      `ROP_AND: rop_out = mode_out & latch;
      `ROP_OR:  rop_out = mode_out | latch;
      `ROP_XOR: rop_out = mode_out ^ latch;
      default:  rop_out = mode_out;
    endcase
    // A zero mask with copy leaves the latch, giving screen copies.
    wr_data = (rop_out & {4{sel_mask}}) | (latch & ~{4{sel_mask}});
  end

  // Host access sequencing: one frame buffer cycle per accepted byte that hits the mapping; a miss completes without one.
  host_state_type state;
  logic [1:0]     rd_lo;
  assign host_ready = state == IDLE;
  assign take       = host_ready && host_req.valid;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= IDLE;
      fb_req    <= '0;
      host_done <= 1'b0;
      rd_lo     <= 2'h0;
    end else begin
      host_done  <= 1'b0;
      fb_req.req <= 1'b0;
      case (state)
        IDLE: begin
          if (take && vga_hit) begin
            fb_req <= '{1'b1, host_req.write, fb_addr, fb_be, wr_data};
            rd_lo  <= a_lo;
            state  <= ISSUE;
          end else if (take) begin
            host_done <= 1'b1;
          end
        end
        ISSUE: begin
          host_done <= fb_req.we;
          state     <= fb_req.we ? IDLE : CAPTURE;
        end
        CAPTURE: begin
          host_done <= 1'b1;
          state     <= IDLE;
        end
        default: state <= IDLE;
      endcase
    end
  end

  // Read modes use the raw frame word, never the rotator.
  logic [1:0] rd_plane;
  logic [7:0] rd_byte, cmp;
  always_comb begin
    rd_plane = read_plane_index;
    if (write_map == `MAP_QUAD) begin
      rd_plane = rd_lo;
    end else if (odd_even_read) begin
      rd_plane = {read_plane_index[1], rd_lo[0]};
    end
    rd_byte = fb_rdata[rd_plane*8 +: 8];
    for (int n = 0; n < 8; n++) begin
      cmp[n] = 1'b1;
      for (int b = 0; b < 4; b++) begin
        if (!plane_match_ignore[b] &&
            fb_rdata[b*8+n] != plane_match_value[b]) begin
          cmp[n] = 1'b0;
        end
      end
    end
  end

  // Latch and read result are captured together on every read that hits the mapping.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch      <= 32'h00000000;
      host_rdata <= 8'h00;
    end else if (state == CAPTURE) begin
      latch      <= fb_rdata;
      host_rdata <= read_mode ? cmp : rd_byte;
    end
  end

  // Trap raised the cycle after the access is seen, before any write.
  logic mem_trap, io_trap;
  logic [4:0] region;
  assign region = host_req.addr[15:11];
  always_comb begin
    mem_trap = 1'b0;
    if (seg == `SEG_A_LO || seg == `SEG_A_HI) begin
      mem_trap = seg_trap_ctl[0] && region_trap_mask[region];
    end else if (seg == `SEG_B_LO) begin
      mem_trap = seg_trap_ctl[1];
    end else if (seg == `SEG_B_HI) begin
      mem_trap = seg_trap_ctl[2];
    end
    case (io_addr[15:4])
      `IO_MONO:  io_trap = io_range_trap_ctl[0];
      `IO_PIXEL_PATH_UNIT:  io_trap = io_range_trap_ctl[1];
      `IO_COLOR: io_trap = io_range_trap_ctl[2];
      default:   io_trap = 1'b0;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smi_trap <= 1'b0;
    end else begin
      smi_trap <= (take && mem_trap) || (io_valid && io_trap);
    end
  end

  // Dot and character clocks as enables; master ticks are pclk pulses.
  logic       mtick, half, dot_tick, char_tick;
  logic [3:0] dot_cnt;
  assign mtick     = clk_sel28 ? mclk28_tick : mclk25_tick;
  assign dot_tick  = mtick && (!dot_halve || half);
  assign char_tick = dot_tick && dot_cnt == (char_nine ? 4'h8 : 4'h7);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half    <= 1'b0;
      dot_cnt <= 4'h0;
    end else begin
      if (mtick) half <= !half;
      if (char_tick) begin
        dot_cnt <= 4'h0;
      end else if (dot_tick) begin
        dot_cnt <= dot_cnt + 4'h1;
      end
    end
  end

  // Refresh address pipe with line and split-screen handling.
  logic [7:0] char_col;
  logic       line_end;
  assign line_end     = char_tick && char_col == chars_per_line;
  assign refresh_addr = char_addr << addr_shift;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      char_addr <= 16'h0000;
      char_col  <= 8'h00;
      scan_line <= 10'h000;
    end else if (line_end) begin
      char_col <= 8'h00;
      if (scan_line == 10'(FRAME_LINES - 1)) begin
        scan_line <= 10'h000;
        char_addr <= 16'h0000;
      end else begin
        scan_line <= scan_line + 10'h001;
        char_addr <= (scan_line + 10'h001 == split_screen_row) ?
                     16'h0000 : char_addr + 16'h0001;
      end
    end else if (char_tick) begin
      char_col  <= char_col + 8'h01;
      char_addr <= char_addr + 16'h0001;
    end
  end

  // Pixel formatting of the fetched word, one pixel per dot, or per two dots in the VGA format.
  logic [31:0] shift_word;
  logic [2:0]  pix;
  logic [3:0]  pix4;
  logic [7:0]  pix8;
  always_comb begin
    pix8 = shift_word[pix[2:1]*8 +: 8];
    for (int j = 0; j < 4; j++) begin
      pix4[j] = shift_word[j*8 + 7 - pix];
    end
    if (pixel_format_field == `PIX_CGA) begin
      pix4 = pix[2] ?
        {shift_word[31 - 2*pix[1:0] -: 2], shift_word[15 - 2*pix[1:0] -: 2]} :
        {shift_word[23 - 2*pix[1:0] -: 2], shift_word[7 - 2*pix[1:0] -: 2]};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_word <= 32'h00000000;
      pix        <= 3'h0;
      dot_valid  <= 1'b0;
      dac_index  <= 8'h00;
    end else begin
      dot_valid <= dot_tick;
      if (char_tick) begin
        shift_word <= refresh_data;
        pix        <= 3'h0;
      end else if (dot_tick && pix != 3'h7) begin
        pix <= pix + 3'h1;
      end
      if (dot_tick) begin
        dac_index <= (pixel_format_field == `PIX_VGA) ? pix8 :
          {color_select, palette[pix4 & palette_input_mask]};
      end
    end
  end

endmodule
`default_nettype wire

// *** common/vga_defs.svh ***
// Register indices, field values, reset values and decode constants.
`ifndef VGA_DEFS_SVH
`define VGA_DEFS_SVH
`define IDX_SEG_TRAP     16'h00B9
`define IDX_REGION_MASK  16'h00BA
`define IDX_IO_TRAP      16'h8004
`define IDX_GFX_CTL      16'h0010
`define IDX_GFX_MASK     16'h0011
`define IDX_REFRESH      16'h0012
`define IDX_STATUS       16'h0013
`define IDX_PAL_BASE     16'h0020
`define SEG_TRAP_RESET   3'h0
`define IO_TRAP_RESET    3'h0
`define REGION_RESET     32'h00000000
`define GFX_CTL_RESET    16'h0000
`define GFX_MASK_RESET   28'hFF0000F
`define REFRESH_RESET    31'h00000000
`define SEG_A_LO         17'h00014
`define SEG_A_HI         17'h00015
`define SEG_B_LO         17'h00016
`define SEG_B_HI         17'h00017
`define IO_MONO          12'h03B
`define IO_PIXEL_PATH_UNIT          12'h03C
`define IO_COLOR         12'h03D
`define MAP_NORMAL       2'h0
`define MAP_ODD_EVEN     2'h1
`define MAP_QUAD         2'h2
`define WM_FILL          2'h0
`define WM_REPLICATE     2'h2
`define WM_FILL_MASKED   2'h3
`define ROP_COPY         2'h0
`define ROP_AND          2'h1
`define ROP_OR           2'h2
`define ROP_XOR          2'h3
`define PIX_CGA          2'h1
`define PIX_EGA          2'h0
`define PIX_VGA          2'h2
`endif

// *** common/vga_pkg.sv ***
// Types shared by the VGA memory path and its bench.
package vga_pkg;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [7:0]  data;
  } host_req_type;
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } fb_req_type;
  typedef enum logic [1:0] {IDLE, ISSUE, CAPTURE} host_state_type;
endpackage

// *** tb/vga_mem_path_checker.sv ***
// Concurrent checks on the VGA memory path ports, bound to its top.
`timescale 1ns/1ps
`default_nettype none
`include "vga_defs.svh"
module vga_mem_path_checker
  import vga_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [17:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire host_req_type host_req,
  input wire logic         host_ready,
  input wire logic         host_done,
  input wire logic [7:0]   host_rdata,
  input wire logic         io_valid,
  input wire logic         smi_trap,
  input wire fb_req_type   fb_req,
  input wire logic [31:0]  fb_rdata
);
  logic      [15:0] ctl;
  logic      [27:0] msk;
  wire logic        reg_wr = psel && penable && pwrite;
  wire logic        wr_req = fb_req.req && fb_req.we;

  // Shadow the datapath controls from APB writes, so each check knows
  // which mapping and write mode the design is in.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= `GFX_CTL_RESET;
      msk <= `GFX_MASK_RESET;
    end else if (reg_wr && paddr[17:2] == `IDX_GFX_CTL) begin
      ctl <= pwdata[15:0];
    end else if (reg_wr && paddr[17:2] == `IDX_GFX_MASK) begin
      msk <= pwdata[27:0];
    end
  end

  // Expected fill-mode word for a copy with every latch bit selected.
  function automatic logic [31:0] fill_word(input logic [7:0] d,
      input logic [2:0] n, input logic [3:0] sel, input logic [3:0] val);
    logic [7:0] r;
    r = (d >> n) | (d << (4'h8 - 4'(n)));
    for (int b = 0; b < 4; b++) begin
      fill_word[8*b +: 8] = sel[b] ? {8{val[b]}} : r;
    end
  endfunction

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_miss_no_fb: assert property (
    host_req.valid && host_ready && host_req.addr[31:17] != 15'h0005
    |=> host_done && !fb_req.req)
    else $error("host miss started a frame buffer cycle");
  chk_dword_addr: assert property (
    fb_req.req |-> fb_req.addr[15:2] == $past(host_req.addr[15:2]))
    else $error("frame buffer address not taken from host address");
  chk_normal_be: assert property (
    wr_req && ctl[11:10] == `MAP_NORMAL |-> fb_req.be == msk[3:0])
    else $error("normal mapping enables differ from plane mask");
  chk_odd_even_map: assert property (
    wr_req && ctl[11:10] == `MAP_ODD_EVEN |-> fb_req.addr[0] == ctl[13]
    && fb_req.be == (($past(host_req.addr[0]) ? 4'hA : 4'h5) & msk[3:0]))
    else $error("odd/even enables or page bit wrong");
  chk_quad_map: assert property (
    wr_req && ctl[11:10] == `MAP_QUAD |-> fb_req.addr[1:0] == 2'h0
    && fb_req.be == ((4'h1 << $past(host_req.addr[1:0])) & msk[3:0]))
    else $error("quad enables or address wrong");
  chk_fill_data: assert property (
    wr_req && ctl[3:0] == 4'h0 && msk[27:20] == 8'hFF |-> fb_req.wdata ==
    fill_word($past(host_req.data), ctl[6:4], msk[7:4], msk[11:8]))
    else $error("fill mode write data wrong");
  chk_read_plane: assert property (
    fb_req.req && !fb_req.we && !ctl[7] && ctl[12:10] == 3'h0
    |-> ##2 host_done &&
    host_rdata == 8'($past(fb_rdata) >> {ctl[9:8], 3'h0}))
    else $error("read plane byte wrong");
  chk_trap_cause: assert property (
    smi_trap |-> $past(io_valid || host_req.valid && host_ready))
    else $error("trap pulse without an access");
endmodule

bind vga_mem_path vga_mem_path_checker vga_mem_path_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .host_req(host_req),
  .host_ready(host_ready), .host_done(host_done), .host_rdata(host_rdata),
  .io_valid(io_valid), .smi_trap(smi_trap), .fb_req(fb_req),
  .fb_rdata(fb_rdata));
`default_nettype wire

// *** tb/fb_model.sv ***
// Frame buffer memory model on the far side of the VGA memory path.
`timescale 1ns/1ps
`default_nettype none
module fb_model
  import vga_pkg::*;
(
  input  wire logic        pclk,
  input  wire fb_req_type  fb_req,
  output logic      [31:0] fb_rdata,
  input  wire logic [15:0] refresh_addr,
  output logic      [31:0] refresh_data
);
  logic [31:0] mem [0:65535];

  // Start cleared so every read returns a known word.
  initial begin
    fb_rdata = 32'h0;
    for (int i = 0; i < 65536; i++) mem[i] = 32'h0;
  end

  // Writes land per enabled byte. Read data stands one cycle only; then
  // the bus shows the inverse so a sample one cycle late can never pass by luck.
  always @(posedge pclk) begin
    fb_rdata <= ~fb_rdata;
    if (fb_req.req && fb_req.we) begin
      for (int b = 0; b < 4; b++) begin
        if (fb_req.be[b]) begin
          mem[fb_req.addr][8*b +: 8] <= fb_req.wdata[8*b +: 8];
        end
      end
    end else if (fb_req.req) begin
      fb_rdata <= mem[fb_req.addr];
    end
  end

  assign refresh_data = mem[refresh_addr];
endmodule
`default_nettype wire

// *** tb/vga_mem_path_tb.sv ***
// Self-checking bench for the VGA memory path.
`timescale 1ns/1ps
`default_nettype none
`include "vga_defs.svh"
module vga_mem_path_tb
  import vga_pkg::*;
;
  localparam logic [15:0] CTL = `IDX_GFX_CTL;
  localparam logic [15:0] MSK = `IDX_GFX_MASK;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [17:0]  paddr = '0;
  logic [31:0]  pwdata = '0, prdata, fb_rdata, refresh_data;
  logic         pready, pslverr, host_ready, host_done, smi_trap, dot_valid;
  logic         io_valid = 0, mclk25_tick = 0;
  logic [15:0]  io_addr = '0, refresh_addr;
  logic [7:0]   host_rdata, dac_index;
  host_req_type host_req = '0;
  fb_req_type   fb_req;
  int           n_mismatch = 0, n_tests = 0, cyc = 0, smi_cnt = 0, dot_cnt = 0;
  logic [31:0]  rop_exp [4] = '{32'h00FF00FF, 32'h00340078, 32'h12FF56FF,
                                32'h12CB5687};
  logic [31:0]  seg_base [3] = '{32'h000A0040, 32'h000B0041, 32'h000B8042};
  logic [31:0]  trap_addr [3] = '{32'h000A0010, 32'h000A0810, 32'h000B0010};
  logic [31:0]  pix_cfg [3] = '{32'h400007A0, 32'h400003A0, 32'h400007B0};
  logic [7:0]   pix_exp [3] = '{8'h95, 8'hAA, 8'h95};

  always #12.5 pclk = ~pclk;

  // Master tick, pulse counters and a watchdog that fails a hung run.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    mclk25_tick <= ~mclk25_tick;
    if (smi_trap) smi_cnt <= smi_cnt + 1;
    if (dot_valid) dot_cnt <= dot_cnt + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end

  vga_mem_path #(.FRAME_LINES(4)) vga_mem_path_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_req(host_req),
    .host_ready(host_ready), .host_done(host_done), .host_rdata(host_rdata),
    .io_valid(io_valid), .io_addr(io_addr), .smi_trap(smi_trap),
    .fb_req(fb_req), .fb_rdata(fb_rdata), .mclk25_tick(mclk25_tick),
    .mclk28_tick(1'b0), .refresh_addr(refresh_addr),
    .refresh_data(refresh_data), .dot_valid(dot_valid),
    .dac_index(dac_index));

  fb_model fb_model_inst (
    .pclk(pclk), .fb_req(fb_req), .fb_rdata(fb_rdata),
    .refresh_addr(refresh_addr), .refresh_data(refresh_data));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] mem_at(input logic [15:0] a);
    return fb_model_inst.mem[a];
  endfunction

  // One APB transfer; an idle cycle follows so psel never moves twice.
  task apb(input logic w, input logic [15:0] i, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    psel <= 1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task wr(input logic [15:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1, i, d, r, e);
  endtask

  task rd(input logic [15:0] i, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(0, i, 32'h0, r, e);
    chk(r, x);
  endtask

  // One host byte access, held until taken, then waited to completion.
  task host(input logic w, input logic [31:0] a, input logic [7:0] d);
    host_req <= '{valid: 1'b1, write: w, addr: a, data: d};
    do @(posedge pclk); while (host_ready !== 1'b1);
    host_req.valid <= 1'b0;
    do @(posedge pclk); while (host_done !== 1'b1);
    @(posedge pclk);
  endtask

  task results();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    logic [31:0] r;
    logic        e;
    int          n;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    // Reset values, reserved trap bits and an unmapped index.
    rd(MSK, 32'h0FF0000F);
    rd(`IDX_SEG_TRAP, 32'h0);
    rd(`IDX_IO_TRAP, 32'h0);
    wr(`IDX_SEG_TRAP, 32'hFF);
    rd(`IDX_SEG_TRAP, 32'h7);
    apb(0, 16'h0100, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    $display("test registers done");
    // Rotate by three, fill planes 0 and 2, plane 3 write-masked.
    fb_model_inst.mem[16'h1234] = 32'h11223344;
    wr(CTL, 32'h0030);
    wr(MSK, 32'h0FF00157);
    host(1, 32'h000A1234, 8'h96);
    chk(mem_at(16'h1234), 32'h1100D2FF);
    $display("test fill write done");
    // Each read plane, odd/even index, then a latch copy write.
    fb_model_inst.mem[16'h0300] = 32'hA1B2C3D4;
    fb_model_inst.mem[16'h0301] = 32'hA1B2C3D4;
    wr(MSK, 32'h0FF0000F);
    for (int p = 0; p < 4; p++) begin
      wr(CTL, p << 8);
      host(0, 32'h000A0300, 8'h0);
      chk(host_rdata, 8'(32'hA1B2C3D4 >> (8 * p)));
    end
    wr(CTL, 32'h1200);
    host(0, 32'h000A0301, 8'h0);
    chk(host_rdata, 32'hA1);
    wr(CTL, 32'h0);
    wr(MSK, 32'h0000000F);
    host(1, 32'h000A0400, 8'h5A);
    chk(mem_at(16'h0400), 32'hA1B2C3D4);
    // Compare read with and without an ignored plane.
    fb_model_inst.mem[16'h0500] = 32'hF00FFF00;
    wr(CTL, 32'h0080);
    wr(MSK, 32'h0FF0200F);
    host(0, 32'h000A0500, 8'h0);
    chk(host_rdata, 32'h00);
    wr(MSK, 32'h0FF8200F);
    host(0, 32'h000A0500, 8'h0);
    chk(host_rdata, 32'hF0);
    $display("test reads done");
    // Replicate mode through every raster operation against the latch.
    fb_model_inst.mem[16'h0600] = 32'h12345678;
    wr(CTL, 32'h0);
    host(0, 32'h000A0600, 8'h0);
    wr(MSK, 32'h0FF0000F);
    for (int op = 0; op < 4; op++) begin
      wr(CTL, 32'h2 | (op << 2));
      host(1, 32'h000A0610, 8'h05);
      chk(mem_at(16'h0610), rop_exp[op]);
    end
    wr(MSK, 32'h00F0000F);
    host(1, 32'h000A0620, 8'h05);
    chk(mem_at(16'h0620), 32'h123B5677);
    wr(CTL, 32'h3);
    wr(MSK, 32'h03C0050F);
    host(1, 32'h000A0630, 8'hF0);
    chk(mem_at(16'h0630), 32'h02344678);
    $display("test write modes done");
    // Odd/even with page select, then quad with a masked-off plane.
    wr(MSK, 32'h0FF0000F);
    wr(CTL, 32'h2400);
    host(1, 32'h000A0700, 8'hAB);
    wr(MSK, 32'h0FF00002);
    host(1, 32'h000A0701, 8'hCD);
    chk(mem_at(16'h0701), 32'h00ABCDAB);
    fb_model_inst.mem[16'h0803] = 32'h77000000;
    wr(CTL, 32'h0800);
    wr(MSK, 32'h0FF0000F);
    for (int i = 0; i < 4; i++) host(1, 32'h000A0800 + i, 8'(16 + i));
    wr(MSK, 32'h0FF0000B);
    host(1, 32'h000A0802, 8'h99);
    chk(mem_at(16'h0800), 32'h13121110);
    host(0, 32'h000A0803, 8'h0);
    chk(host_rdata, 32'h13);
    $display("test mappings done");
    // Each host segment mapping against all three segments.
    wr(MSK, 32'h0FF0000F);
    for (int m = 0; m < 3; m++) begin
      wr(CTL, m << 14);
      for (int s = 0; s < 3; s++) begin
        fb_model_inst.mem[seg_base[s][15:0]] = 32'h0;
        host(1, seg_base[s], 8'h5A);
        chk(mem_at(seg_base[s][15:0]), 32'h5A5A5A5A * (s == m));
      end
    end
    wr(CTL, 32'h0);
    host(1, 32'h010A0040, 8'h77);
    chk(mem_at(16'h0040), 32'h0);
    $display("test segments done");
    // Memory traps with a region mask, then the three I/O ranges.
    wr(`IDX_SEG_TRAP, 32'h3);
    wr(`IDX_REGION_MASK, 32'h1);
    for (int t = 0; t < 3; t++) begin
      n = smi_cnt;
      host(0, trap_addr[t], 8'h0);
      repeat (2) @(posedge pclk);
      chk(smi_cnt - n, t != 1);
    end
    wr(`IDX_IO_TRAP, 32'h2);
    for (int k = 0; k < 3; k++) begin
      n = smi_cnt;
      io_valid <= 1;
      io_addr <= 16'h03B4 + 16'(k * 16);
      @(posedge pclk);
      io_valid <= 0;
      repeat (3) @(posedge pclk);
      chk(smi_cnt - n, k == 1);
    end
    chk(dot_cnt != 0, 32'h1);
    $display("test traps done");
    // CGA planes through the masked palette, then a refresh shift of two.
    // Only words 0, 4, 8 and 12 hold pixels in the last pass, so an
    // unshifted refresh address would show blank characters.
    wr(`IDX_PAL_BASE + 16'hD, 32'h15);
    wr(`IDX_PAL_BASE + 16'h5, 32'h2A);
    for (int i = 0; i < 13; i++) begin
      fb_model_inst.mem[i] = (i < 4 || i % 4 == 0) ? 32'hFFFF5555 : 32'h0;
    end
    for (int q = 0; q < 3; q++) begin
      if (q == 2) for (int i = 1; i < 4; i++) fb_model_inst.mem[i] = 32'h0;
      wr(`IDX_REFRESH, pix_cfg[q]);
      repeat (40) @(posedge pclk);
      repeat (64) begin
        @(posedge pclk);
        chk(dac_index, pix_exp[q]);
      end
    end
    $display("test pixels done");
    results();
  end
endmodule
`default_nettype wire
